// >>> design/csrb_defs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes an 8-bit register port and a 40 MHz master clock.
`ifndef CSRB_DEFS_SVH
`define CSRB_DEFS_SVH

`define CSRB_OFS_PRIO_FIRST 8'h49
`define CSRB_OFS_PRIO_SECOND 8'h4a
`define CSRB_OFS_PHASE_MEASURE_VALUE_HIGH 8'h4b
`define CSRB_OFS_PHASE_MEASURE_VALUE_LOW 8'h4c
`define CSRB_OFS_ADJUST 8'h4d
`define CSRB_OFS_VALID_FIRST 8'h4e

`define CSRB_B_MEASURE_OVERFLOW_FLAG 6
`define CSRB_B_MEASURE_READY_IRQ_ENABLE 5
`define CSRB_B_MEASURE_READY_FLAG 4
`define CSRB_B_MBUSY 3
`define CSRB_B_ADJUST_DONE_IRQ_ENABLE 3
`define CSRB_B_ADJUST_DONE_FLAG 2
`define CSRB_B_ABUSY 1
`define CSRB_B_ARMED 0
`define CSRB_B_IC1 0
`define CSRB_B_INPUT_ONE_CHANGE_FLAG 1
`define CSRB_B_INPUT_ONE_IRQ_ENABLE 2
`define CSRB_B_IC2 4
`define CSRB_B_INPUT_TWO_CHANGE_FLAG 5
`define CSRB_B_INPUT_TWO_IRQ_ENABLE 6

`define CSRB_RST_ADJUST_DONE_FLAG 1'b1
`define CSRB_RST_CHANGE 1'b1

`define CSRB_CLK_PERIOD_NS 25
`define CSRB_VALID_TIME_NS 1000
`define CSRB_VALID_CYCLES \
    ((`CSRB_VALID_TIME_NS + `CSRB_CLK_PERIOD_NS - 1) / `CSRB_CLK_PERIOD_NS)

`endif

// >>> design/csrb_pkg.sv
// Types shared by the status register bank
// Assumes nothing beyond a SystemVerilog compiler.
package csrb_pkg;
    typedef enum logic [1:0] {
        CSRB_REF_NONE = 2'b00,
        CSRB_REF_ONE = 2'b01,
        CSRB_REF_TWO = 2'b10,
        CSRB_REF_THREE = 2'b11
    } csrb_ref_e;
    typedef logic [10:0] csrb_phase_t;
endpackage : csrb_pkg

// >>> design/csrb_valid_timer.sv
// Validation timer for one input clock
// Assumes rawValid is synchronous to clk.
`timescale 1ns/1ps
`include "csrb_defs.svh"

module csrb_valid_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rawValid,
    output logic timedValid
);
    localparam logic [15:0] VALID_CYCLES = 16'(`CSRB_VALID_CYCLES);

    logic [15:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (!rawValid) begin
            count <= 16'h0000;
        end else if (count < VALID_CYCLES) begin
            count <= count + 16'h0001;
        end
    end

    // Drops on the first edge that samples raw valid low so a bad input is never kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timedValid <= 1'b0;
        end else begin
            timedValid <= rawValid && (count >= VALID_CYCLES - 16'h0001);
        end
    end

    property p_timed_drop;
        @(posedge clk) disable iff (!rst_n)
        !rawValid |=> !timedValid;
    endproperty
    a_timed_drop: assert property (p_timed_drop) else $error("timed valid kept");

    property p_timed_needs_time;
        @(posedge clk) disable iff (!rst_n)
        $rose(timedValid) |-> $past(count) == VALID_CYCLES - 16'h0001;
    endproperty
    a_timed_needs_time: assert property (p_timed_needs_time) else $error("timed early");
endmodule : csrb_valid_timer

// >>> design/csrb_status_bank.sv
// Status register bank: reference ranking, phase measure, phase adjust
// and input valid status. Assumes engines run on clk; the lock inputs
// come from the analog loop and are synchronised here.
`timescale 1ns/1ps
`include "csrb_defs.svh"

module csrb_status_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic apllLockPrimaryPin,
    input wire logic apllLockSecondaryPin,
    output logic apllLockPrimary,
    output logic apllLockSecondary,
    input wire logic [2:0] rawValid,
    input wire logic [2:0] lockTimeout,
    input wire logic [2:0] inputValidationControl,
    input wire logic [5:0] priorityOrder,
    input wire logic revertiveSwitching,
    input wire logic measureBusyIn,
    input wire logic measureDone,
    input wire logic measureOverflow,
    input wire logic [10:0] measureValueIn,
    input wire logic adjustArmedIn,
    input wire logic adjustBusyIn,
    input wire logic adjustDone,
    output logic measureIrqSummary,
    output logic adjustIrqSummary,
    output logic [1:0] inputIrq
);
    // True when code names an input that may be reported
    function automatic logic refUsable(input logic [1:0] code, input logic [2:0] ok);
        logic r;
        r = 1'b0;
        if (code != csrb_pkg::CSRB_REF_NONE) begin
            r = ok[code - 2'd1];
        end
        return r;
    endfunction : refUsable

    // Compacts the priority order to usable inputs, best first
    function automatic logic [5:0] rankRefs(input logic [5:0] order, input logic [2:0] ok);
        logic [5:0] r;
        logic [1:0] slot;
        logic [1:0] code;
        r = 6'h00;
        slot = 2'd0;
        for (int i = 0; i < 3; i++) begin
            code = order[i*2 +: 2];
            if (refUsable(code, ok)) begin
                r[slot*2 +: 2] = code;
                slot = slot + 2'd1;
            end
        end
        return r;
    endfunction : rankRefs

    function automatic logic clearHit(input logic [7:0] a, input logic [7:0] ofs,
                                      input logic we);
        return we && (a == ofs);
    endfunction : clearHit

    logic [1:0] lockMeta;
    logic [1:0] lockSync;
    logic [2:0] timedValid;
    logic [2:0] inputValid;
    logic [2:0] eligible;
    logic [5:0] ranked;
    logic [1:0] topRef;
    logic [1:0] secondRef;
    logic [1:0] thirdRef;
    logic [1:0] selectedRef;
    logic [1:0] next_selectedRef;
    csrb_pkg::csrb_phase_t phaseValue;
    logic measureBusy;
    logic measureReadyFlag;
    logic overflowFlag;
    logic readyIrqEnable;
    logic adjustArmed;
    logic adjustBusy;
    logic adjustDoneFlag;
    logic adjustIrqEnable;
    logic [1:0] changeFlag;
    logic [1:0] changeIrqEnable;
    logic wrMeas;
    logic wrAdjust;
    logic wrValid;

    assign wrMeas = clearHit(regAddr, `CSRB_OFS_PHASE_MEASURE_VALUE_HIGH, regWrite);
    assign wrAdjust = clearHit(regAddr, `CSRB_OFS_ADJUST, regWrite);
    assign wrValid = clearHit(regAddr, `CSRB_OFS_VALID_FIRST, regWrite);

    // Lock levels come from the analog loop, so they are synchronised
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockMeta <= 2'b00;
            lockSync <= 2'b00;
        end else begin
            lockMeta <= {apllLockSecondaryPin, apllLockPrimaryPin};
            lockSync <= lockMeta;
        end
    end

    // Both bits are exported separately; the host combines them
    assign apllLockPrimary = lockSync[0];
    assign apllLockSecondary = lockSync[1];

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_input
            csrb_valid_timer u_timer (
                .clk(clk),
                .rst_n(rst_n),
                .rawValid(rawValid[g]),
                .timedValid(timedValid[g])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inputValid <= 3'b000;
        end else begin
            inputValid <= timedValid & ~lockTimeout;
        end
    end

    assign eligible = inputValid & ~inputValidationControl;
    assign ranked = rankRefs(priorityOrder, eligible);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            topRef <= csrb_pkg::CSRB_REF_NONE;
            secondRef <= csrb_pkg::CSRB_REF_NONE;
            thirdRef <= csrb_pkg::CSRB_REF_NONE;
        end else begin
            topRef <= ranked[1:0];
            secondRef <= ranked[3:2];
            thirdRef <= ranked[5:4];
        end
    end

    // Nonrevertive keeps a still-usable choice even when outranked
    always_comb begin
        next_selectedRef = ranked[1:0];
        if (!revertiveSwitching && refUsable(selectedRef, eligible)) begin
            next_selectedRef = selectedRef;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selectedRef <= csrb_pkg::CSRB_REF_NONE;
        end else begin
            selectedRef <= next_selectedRef;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseValue <= 11'h000;
            measureBusy <= 1'b0;
        end else begin
            measureBusy <= measureBusyIn;
            if (measureDone) begin
                phaseValue <= measureValueIn;
            end
        end
    end

    // Set wins over a clearing write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            measureReadyFlag <= 1'b0;
            overflowFlag <= 1'b0;
        end else begin
            if (measureDone) begin
                measureReadyFlag <= 1'b1;
            end else if (wrMeas && regWdata[`CSRB_B_MEASURE_READY_FLAG]) begin
                measureReadyFlag <= 1'b0;
            end
            if (measureDone && measureOverflow) begin
                overflowFlag <= 1'b1;
            end else if (wrMeas && regWdata[`CSRB_B_MEASURE_OVERFLOW_FLAG]) begin
                overflowFlag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readyIrqEnable <= 1'b0;
        end else if (wrMeas) begin
            readyIrqEnable <= regWdata[`CSRB_B_MEASURE_READY_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adjustArmed <= 1'b0;
            adjustBusy <= 1'b0;
        end else begin
            adjustArmed <= adjustArmedIn;
            adjustBusy <= adjustBusyIn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adjustDoneFlag <= `CSRB_RST_ADJUST_DONE_FLAG;
        end else if (adjustDone) begin
            adjustDoneFlag <= 1'b1;
        end else if (wrAdjust && regWdata[`CSRB_B_ADJUST_DONE_FLAG]) begin
            adjustDoneFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adjustIrqEnable <= 1'b0;
        end else if (wrAdjust) begin
            adjustIrqEnable <= regWdata[`CSRB_B_ADJUST_DONE_IRQ_ENABLE];
        end
    end

    // Change flags watch the registered valid bits of inputs one and two
    logic [1:0] prevValid;
    logic [1:0] clearChange;
    assign clearChange = {regWdata[`CSRB_B_INPUT_TWO_CHANGE_FLAG], regWdata[`CSRB_B_INPUT_ONE_CHANGE_FLAG]} & {2{wrValid}};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prevValid <= 2'b00;
        end else begin
            prevValid <= inputValid[1:0];
        end
    end

    generate
        for (g = 0; g < 2; g++) begin : gen_change
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    changeFlag[g] <= `CSRB_RST_CHANGE;
                end else if (inputValid[g] != prevValid[g]) begin
                    changeFlag[g] <= 1'b1;
                end else if (clearChange[g]) begin
                    changeFlag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            changeIrqEnable <= 2'b00;
        end else if (wrValid) begin
            changeIrqEnable <= {regWdata[`CSRB_B_INPUT_TWO_IRQ_ENABLE], regWdata[`CSRB_B_INPUT_ONE_IRQ_ENABLE]};
        end
    end

    // Overflow has no enable of its own, so only ready feeds the summary
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            measureIrqSummary <= 1'b0;
            adjustIrqSummary <= 1'b0;
            inputIrq <= 2'b00;
        end else begin
            measureIrqSummary <= measureReadyFlag && readyIrqEnable;
            adjustIrqSummary <= adjustDoneFlag && adjustIrqEnable;
            inputIrq <= changeFlag & changeIrqEnable;
        end
    end

    // Read data is registered; unmapped addresses and unused bits read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= 8'h00;
            case (regAddr)
                `CSRB_OFS_PRIO_FIRST: begin
                    regRdata[5:4] <= topRef;
                    regRdata[1:0] <= selectedRef;
                end
                `CSRB_OFS_PRIO_SECOND: begin
                    regRdata[5:4] <= thirdRef;
                    regRdata[1:0] <= secondRef;
                end
                `CSRB_OFS_PHASE_MEASURE_VALUE_HIGH: begin
                    regRdata[`CSRB_B_MEASURE_OVERFLOW_FLAG] <= overflowFlag;
                    regRdata[`CSRB_B_MEASURE_READY_IRQ_ENABLE] <= readyIrqEnable;
                    regRdata[`CSRB_B_MEASURE_READY_FLAG] <= measureReadyFlag;
                    regRdata[`CSRB_B_MBUSY] <= measureBusy;
                    regRdata[2:0] <= phaseValue[10:8];
                end
                `CSRB_OFS_PHASE_MEASURE_VALUE_LOW: begin
                    regRdata <= phaseValue[7:0];
                end
                `CSRB_OFS_ADJUST: begin
                    regRdata[`CSRB_B_ADJUST_DONE_IRQ_ENABLE] <= adjustIrqEnable;
                    regRdata[`CSRB_B_ADJUST_DONE_FLAG] <= adjustDoneFlag;
                    regRdata[`CSRB_B_ABUSY] <= adjustBusy;
                    regRdata[`CSRB_B_ARMED] <= adjustArmed;
                end
                `CSRB_OFS_VALID_FIRST: begin
                    regRdata[`CSRB_B_INPUT_TWO_IRQ_ENABLE] <= changeIrqEnable[1];
                    regRdata[`CSRB_B_INPUT_TWO_CHANGE_FLAG] <= changeFlag[1];
                    regRdata[`CSRB_B_IC2] <= inputValid[1];
                    regRdata[`CSRB_B_INPUT_ONE_IRQ_ENABLE] <= changeIrqEnable[0];
                    regRdata[`CSRB_B_INPUT_ONE_CHANGE_FLAG] <= changeFlag[0];
                    regRdata[`CSRB_B_IC1] <= inputValid[0];
                end
                default: begin
                    regRdata <= 8'h00;
                end
            endcase
        end
    end

    property p_top_usable;
        @(posedge clk) disable iff (!rst_n)
        topRef != 2'b00 |-> refUsable(topRef, $past(eligible));
    endproperty
    a_top_usable: assert property (p_top_usable) else $error("top ref unusable");

    property p_top_none;
        @(posedge clk) disable iff (!rst_n)
        eligible == 3'b000 |=> topRef == 2'b00;
    endproperty
    a_top_none: assert property (p_top_none) else $error("top ref not none");

    property p_sel_usable;
        @(posedge clk) disable iff (!rst_n)
        selectedRef != 2'b00 |-> refUsable(selectedRef, $past(eligible));
    endproperty
    a_sel_usable: assert property (p_sel_usable) else $error("selected unusable");

    property p_revertive_switching_follows;
        @(posedge clk) disable iff (!rst_n)
        revertiveSwitching |=> selectedRef == $past(ranked[1:0]);
    endproperty
    a_revertive_switching_follows: assert property (p_revertive_switching_follows) else $error("revertive_switching lag");

    property p_phase_capture;
        @(posedge clk) disable iff (!rst_n)
        measureDone |=> phaseValue == $past(measureValueIn) ##1 measureReadyFlag || measureDone;
    endproperty
    a_phase_capture: assert property (p_phase_capture) else $error("phase lost");

    property p_ready_set;
        @(posedge clk) disable iff (!rst_n)
        measureDone |=> measureReadyFlag;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_measure_overflow_flag_set;
        @(posedge clk) disable iff (!rst_n)
        measureDone && measureOverflow |=> overflowFlag;
    endproperty
    a_measure_overflow_flag_set: assert property (p_measure_overflow_flag_set) else $error("overflow not set");

    property p_adjust_done_flag_clear;
        @(posedge clk) disable iff (!rst_n)
        wrAdjust && regWdata[`CSRB_B_ADJUST_DONE_FLAG] && !adjustDone |=> !adjustDoneFlag;
    endproperty
    a_adjust_done_flag_clear: assert property (p_adjust_done_flag_clear) else $error("adjust flag kept");

    property p_valid_eq;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> inputValid == $past(timedValid & ~lockTimeout);
    endproperty
    a_valid_eq: assert property (p_valid_eq) else $error("valid mismatch");

    property p_change_set;
        @(posedge clk) disable iff (!rst_n)
        inputValid[0] != prevValid[0] |=> changeFlag[0];
    endproperty
    a_change_set: assert property (p_change_set) else $error("change missed");

    property p_phase_measure_value_irq;
        @(posedge clk) disable iff (!rst_n)
        measureIrqSummary |-> $past(measureReadyFlag && readyIrqEnable);
    endproperty
    a_phase_measure_value_irq: assert property (p_phase_measure_value_irq) else $error("measure irq ungated");
endmodule : csrb_status_bank

// >>> sim/csrb_host_model.sv
// Host processor model driving the register strobe port of the status bank
// Assumes one shared clock; read data is valid the edge after the strobe.
`timescale 1ns/1ps

module csrb_host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic apllLockPrimary,
    input wire logic apllLockSecondary,
    output logic hostLocked,
    output logic readSeen
);
    logic chkRead;

    initial begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'h0;
        regRead = 1'h0;
        readSeen = 1'h0;
        chkRead = 1'h0;
    end

    // Either lock bit alone does not mean the loop is usable
    assign hostLocked = apllLockPrimary & apllLockSecondary;

    // Only reads that carry an expectation are announced to the bench
    always @(posedge clk) readSeen <= regRead & chkRead;

    // Released address and data show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic chk, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'h1;
        chkRead <= chk;
        @(posedge clk);
        regRead <= 1'h0;
        regAddr <= ~a;
        @(negedge clk);
        d = regRdata;
    endtask : rd

    // A result is trusted only when idle, ready and free of overflow
    function automatic logic trusted(input logic [7:0] st);
        return !st[3] && st[4] && !st[6];
    endfunction : trusted

    // The finished flag is not reliable for fast dividers, so busy is polled
    task automatic wait_adjust_idle(output logic idle);
        logic [7:0] s;
        idle = 1'h0;
        for (int i = 0; i < 20 && !idle; i++) begin
            rd(8'h4d, 1'h0, s);
            idle = !s[1];
        end
    endtask : wait_adjust_idle
endmodule : csrb_host_model

// >>> sim/clock_status_register_bank_bench.sv
// Self-checking bench for the clock status register bank
// Assumes the host model owns the register port; reads are compared at negedge.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module clock_status_register_bank_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] regAddr, regWdata, regRdata, got, expHead;
    logic regWrite, regRead, readSeen, hostLocked, idle;
    logic lockPriPin = 1'h0, lockSecPin = 1'h0, apllLockPrimary, apllLockSecondary;
    logic measureIrqSummary, adjustIrqSummary;
    logic [1:0] inputIrq;
    logic [2:0] rawValid = 3'h0, lockTimeout = 3'h0, validCtl = 3'h0;
    logic [5:0] prio = 6'h00;
    logic revertive_switching = 1'h1, mBusy = 1'h0, mDone = 1'h0, mOvf = 1'h0;
    logic aArmed = 1'h0, aBusy = 1'h0, aDone = 1'h0;
    logic [10:0] mVal = 11'h000, v;
    logic [31:0] seed = 32'h25;
    logic [7:0] expQ[$];
    int fails = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    csrb_status_bank uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .apllLockPrimaryPin(lockPriPin), .apllLockSecondaryPin(lockSecPin),
        .apllLockPrimary(apllLockPrimary), .apllLockSecondary(apllLockSecondary),
        .rawValid(rawValid), .lockTimeout(lockTimeout), .inputValidationControl(validCtl),
        .priorityOrder(prio), .revertiveSwitching(revertive_switching), .measureBusyIn(mBusy),
        .measureDone(mDone), .measureOverflow(mOvf), .measureValueIn(mVal),
        .adjustArmedIn(aArmed), .adjustBusyIn(aBusy), .adjustDone(aDone),
        .measureIrqSummary(measureIrqSummary), .adjustIrqSummary(adjustIrqSummary),
        .inputIrq(inputIrq));

    csrb_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .apllLockPrimary(apllLockPrimary), .apllLockSecondary(apllLockSecondary),
        .hostLocked(hostLocked), .readSeen(readSeen));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic print_verdict();
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(a, 1'h1, got);
    endtask : rdx

    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask : waitn

    task automatic phase_measure_value(input logic [10:0] val, input logic ovf);
        @(posedge clk);
        mBusy <= 1'h1;
        repeat (3) @(posedge clk);
        mVal <= val;
        mOvf <= ovf;
        mDone <= 1'h1;
        mBusy <= 1'h0;
        @(posedge clk);
        mDone <= 1'h0;
        mOvf <= 1'h0;
    endtask : phase_measure_value

    always @(negedge clk) begin
        if (readSeen === 1'h1) begin
            expHead = (expQ.size() > 0) ? expQ.pop_front() : ~regRdata;
            `CHK(regRdata, expHead)
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        rdx(8'h49, 8'h00);
        rdx(8'h4a, 8'h00);
        rdx(8'h4b, 8'h00);
        rdx(8'h4c, 8'h00);
        rdx(8'h4d, 8'h04);
        rdx(8'h4e, 8'h22);
        rdx(8'h50, 8'h00);
        host.wr(8'h49, 8'hff);
        rdx(8'h49, 8'h00);
        `CHK(adjustIrqSummary, 1'h0)
        @(posedge clk);
        lockPriPin <= 1'h1;
        waitn(4);
        `CHK(hostLocked, 1'h0)
        @(posedge clk);
        lockSecPin <= 1'h1;
        waitn(4);
        `CHK(hostLocked, 1'h1)
        // Measurement: busy, disabled interrupt, then boundary and random values
        @(posedge clk);
        mBusy <= 1'h1;
        rdx(8'h4b, 8'h08);
        phase_measure_value(11'h000, 1'h0);
        waitn(2);
        `CHK(measureIrqSummary, 1'h0)
        host.wr(8'h4b, 8'h30);
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 11'h3ff : (i == 1) ? 11'h400 : seed[10:0];
            phase_measure_value(v, 1'h0);
            waitn(2);
            `CHK(measureIrqSummary, 1'h1)
            host.wr(8'h4b, 8'h20);
            rdx(8'h4b, {5'h06, v[10:8]});
            `CHK(host.trusted(got), 1'h1)
            rdx(8'h4c, v[7:0]);
            host.wr(8'h4b, 8'h30);
            rdx(8'h4b, {5'h04, v[10:8]});
            `CHK(measureIrqSummary, 1'h0)
        end
        phase_measure_value(v, 1'h1);
        rdx(8'h4b, {5'h0e, v[10:8]});
        `CHK(host.trusted(got), 1'h0)
        host.wr(8'h4b, 8'h70);
        rdx(8'h4b, {5'h04, v[10:8]});
        // Phase adjust: armed, busy, finished with interrupt
        host.wr(8'h4d, 8'h04);
        rdx(8'h4d, 8'h00);
        @(posedge clk);
        aArmed <= 1'h1;
        rdx(8'h4d, 8'h01);
        @(posedge clk);
        aArmed <= 1'h0;
        aBusy <= 1'h1;
        rdx(8'h4d, 8'h02);
        host.wr(8'h4d, 8'h08);
        @(posedge clk);
        aBusy <= 1'h0;
        aDone <= 1'h1;
        @(posedge clk);
        aDone <= 1'h0;
        waitn(2);
        `CHK(adjustIrqSummary, 1'h1)
        rdx(8'h4d, 8'h0c);
        host.wait_adjust_idle(idle);
        `CHK(idle, 1'h1)
        host.wr(8'h4d, 8'h0c);
        rdx(8'h4d, 8'h08);
        `CHK(adjustIrqSummary, 1'h0)
        // Input valid chain and reference ranking; order is two, three, one
        @(posedge clk);
        prio <= 6'h1e;
        host.wr(8'h4e, 8'h22);
        @(posedge clk);
        rawValid <= 3'h1;
        repeat (30) @(posedge clk);
        rdx(8'h4e, 8'h00);
        repeat (20) @(posedge clk);
        rdx(8'h4e, 8'h03);
        rdx(8'h49, 8'h11);
        rdx(8'h4a, 8'h00);
        @(posedge clk);
        revertive_switching <= 1'h0;
        rawValid <= 3'h3;
        repeat (50) @(posedge clk);
        rdx(8'h49, 8'h21);
        rdx(8'h4a, 8'h01);
        rdx(8'h4e, 8'h33);
        @(posedge clk);
        rawValid <= 3'h7;
        validCtl <= 3'h3;
        repeat (50) @(posedge clk);
        rdx(8'h49, 8'h33);
        rdx(8'h4a, 8'h00);
        @(posedge clk);
        validCtl <= 3'h0;
        revertive_switching <= 1'h1;
        repeat (5) @(posedge clk);
        rdx(8'h49, 8'h22);
        rdx(8'h4a, 8'h13);
        host.wr(8'h4e, 8'h22);
        rdx(8'h4e, 8'h11);
        host.wr(8'h4e, 8'h40);
        @(posedge clk);
        lockTimeout <= 3'h2;
        repeat (5) @(posedge clk);
        rdx(8'h4e, 8'h61);
        `CHK(inputIrq, 2'h2)
        host.wr(8'h4e, 8'h60);
        rdx(8'h4e, 8'h41);
        `CHK(inputIrq, 2'h0)
        // Input one's enable path: drop its valid and expect only its request
        host.wr(8'h4e, 8'h04);
        @(posedge clk);
        rawValid <= 3'h6;
        repeat (5) @(posedge clk);
        rdx(8'h4e, 8'h06);
        `CHK(inputIrq, 2'h1)
        waitn(2);
        print_verdict();
    end
endmodule : clock_status_register_bank_bench
